// ==== dv/lsch_chk_properties.sv ====
// checker: port-level properties of the command handler
module lsch_chk_properties #(
	parameter int unsigned REPORT_CYCLES = 20
) (
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	input wire lsch_pkg::lsch_apb_req_t apbReq,
	input wire lsch_pkg::lsch_apb_rsp_t apbRsp,
	input wire lsch_pkg::lsch_cmd_t     cmdIn,
	input wire logic                    cmdReady,
	input wire lsch_pkg::lsch_ans_t     ansOut,
	input wire logic                    ansReady,
	input wire lsch_pkg::lsch_enum_t    enumIn,
	input wire logic                    bootLoad,
	input wire lsch_pkg::lsch_boot_t    bootState,
	input wire lsch_pkg::lsch_boot_t    liveState,
	input wire logic [31:0]             reportMask,
	input wire logic                    reportTick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic       firstB;
	logic [7:0] cmdType;
	// remembers the type byte of the packet being handled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			firstB  <= 1'b1;
			cmdType <= 8'h00;
		end else if (cmdIn.valid && cmdReady && firstB) begin
			firstB  <= 1'b0;
			cmdType <= cmdIn.data;
		end else if (ansOut.valid && ansReady && ansOut.last) begin
			firstB <= 1'b1;
		end
	end
	property p_ansType;
		$rose(ansOut.valid) |-> ansOut.data[5:0] == cmdType[5:0];
	endproperty
	a_ansType: assert property (p_ansType)
		else $error("answer type does not match command");
	property p_ansEnd;
		ansOut.valid && ansReady && ansOut.last |=> !ansOut.valid;
	endproperty
	a_ansEnd: assert property (p_ansEnd)
		else $error("answer runs past its last byte");
	property p_busy;
		ansOut.valid |-> !cmdReady;
	endproperty
	a_busy: assert property (p_busy)
		else $error("command taken while answering");
	property p_hold;
		ansOut.valid && !ansReady |=> ansOut.valid && $stable(ansOut.data);
	endproperty
	a_hold: assert property (p_hold)
		else $error("answer byte lost while stalled");
	property p_tick;
		reportTick |-> ($past(reportMask) != 32'h0) ##1 (!reportTick) [*8];
	endproperty
	a_tick: assert property (p_tick)
		else $error("report tick without mask or too soon");
	property p_boot;
		bootLoad |=> liveState == $past(bootState);
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot state not loaded");
	property p_mask;
		!$stable(reportMask) |-> $past(!cmdReady && !ansOut.valid);
	endproperty
	a_mask: assert property (p_mask)
		else $error("report mask changed outside execution");
	property p_state;
		!$stable(liveState) |->
			$past(bootLoad || (!cmdReady && !ansOut.valid));
	endproperty
	a_state: assert property (p_state)
		else $error("live state changed outside execution");
endmodule : lsch_chk_properties

bind lsch_command_handler lsch_chk_properties #(
	.REPORT_CYCLES(REPORT_CYCLES)
) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
	.cmdIn(cmdIn), .cmdReady(cmdReady), .ansOut(ansOut),
	.ansReady(ansReady), .enumIn(enumIn), .bootLoad(bootLoad),
	.bootState(bootState), .liveState(liveState),
	.reportMask(reportMask), .reportTick(reportTick)
);

// ==== dv/lsch_host_model.sv ====
// host model: sends command packets, collects answer bytes
module lsch_host_model (
	input  wire logic                clk_sys,
	input  wire logic                cmdReady,
	input  wire lsch_pkg::lsch_ans_t ansOut,
	output      lsch_pkg::lsch_cmd_t cmdIn,
	output      logic                ansReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       slow;
	logic [7:0] ans[$];
	initial begin
		cmdIn    = '0;
		ansReady = 1'b1;
		slow     = 1'b0;
	end
	// each byte held until taken; idle data inverted
	task automatic xfer(input logic [7:0] c[$]);
		logic done;
		ans = {};
		foreach (c[i]) begin
			cmdIn <= '{1'b1, c[i]};
			done = 1'b0;
			while (!done) begin
				@(negedge clk_sys);
				done = cmdReady;
				@(posedge clk_sys);
			end
		end
		cmdIn <= '{1'b0, ~c[c.size()-1]};
		done = 1'b0;
		while (!done) begin
			@(negedge clk_sys);
			if (ansOut.valid && ansReady) begin
				ans.push_back(ansOut.data);
				done = ansOut.last;
			end
			@(posedge clk_sys);
			ansReady <= slow ? ~ansReady : 1'b1;
		end
	endtask : xfer
endmodule : lsch_host_model

// ==== dv/test_lcd_sensor_command_handler.sv ====
// testbench: command packets, boot load, sensors and registers
module test_lcd_sensor_command_handler;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned RC = 20;
	localparam logic [7:0] FAM = 8'h5A; // arbitrary family code
	localparam logic [63:0] SID = {56'h01020304050607, FAM};
	typedef struct packed {
		logic [47:0] cmd;
		logic [2:0]  n;
		logic        ok;
		logic [30:0] st;
	} lsch_row_t;
	logic                    clk_sys, rst_n, cmdReady, ansReady;
	logic                    bootLoad, reportTick, er;
	lsch_pkg::lsch_apb_req_t apbReq;
	lsch_pkg::lsch_apb_rsp_t apbRsp;
	lsch_pkg::lsch_cmd_t     cmdIn;
	lsch_pkg::lsch_ans_t     ansOut;
	lsch_pkg::lsch_enum_t    enumIn;
	lsch_pkg::lsch_boot_t    bootState, liveState;
	logic [31:0]             reportMask, rd;
	logic [7:0]              c[$];
	logic [7:0]              t;
	int                      error_cnt, compares, cyc, tk[$];
	lsch_row_t rows[15] = '{
		'{48'h0B0205010000, 3'd4, 1'b1, 31'h15106464},
		'{48'h0B0210000000, 3'd4, 1'b0, 31'h15106464},
		'{48'h0B020F020000, 3'd4, 1'b0, 31'h15106464},
		'{48'h0C0101000000, 3'd3, 1'b1, 31'h35106464},
		'{48'h0C0102000000, 3'd3, 1'b1, 31'h55106464},
		'{48'h0C0103000000, 3'd3, 1'b1, 31'h75106464},
		'{48'h0C0104000000, 3'd3, 1'b0, 31'h75106464},
		'{48'h0D01C8000000, 3'd3, 1'b1, 31'h75C86464},
		'{48'h0D01C9000000, 3'd3, 1'b0, 31'h75C86464},
		'{48'h0D02FF210000, 3'd4, 1'b1, 31'h75216464},
		'{48'h0E0155000000, 3'd3, 1'b1, 31'h75215555},
		'{48'h0E0211220000, 3'd4, 1'b1, 31'h75211122},
		'{48'h0D0000000000, 3'd2, 1'b0, 31'h75211122},
		'{48'h200000000000, 3'd2, 1'b0, 31'h75211122},
		'{48'h0C0100000000, 3'd3, 1'b1, 31'h15211122}
	};
	lsch_command_handler #(.REPORT_CYCLES(RC)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
		.cmdIn(cmdIn), .cmdReady(cmdReady), .ansOut(ansOut),
		.ansReady(ansReady), .enumIn(enumIn), .bootLoad(bootLoad),
		.bootState(bootState), .liveState(liveState),
		.reportMask(reportMask), .reportTick(reportTick)
	);
	lsch_host_model host (
		.clk_sys(clk_sys), .cmdReady(cmdReady), .ansOut(ansOut),
		.cmdIn(cmdIn), .ansReady(ansReady)
	);
	task automatic test_done();
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [63:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic pkt(input logic [7:0] q[$], input logic [7:0] e[$]);
		host.xfer(q);
		chk("answer length", e.size(), host.ans.size());
		foreach (e[i]) chk("answer byte", e[i], host.ans[i]);
	endtask : pkt
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic r;
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge clk_sys);
			r = apbRsp.pready;
			rd = apbRsp.prdata;
			er = apbRsp.pslverr;
			@(posedge clk_sys);
		end
		apbReq <= '{1'b0, 1'b0, w, a, d};
		@(posedge clk_sys);
	endtask : apb
	task automatic ticks(input int k);
		tk = {};
		for (int i = 0; i < k; i++) begin
			@(negedge clk_sys);
			if (reportTick) tk.push_back(i);
		end
		@(posedge clk_sys);
	endtask : ticks
	function automatic logic [30:0] lv();
		return {liveState.curStyle, liveState.curRow, liveState.curCol,
			liveState.contrast, liveState.lcdLight, liveState.keyLight};
	endfunction : lv
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		rst_n = 1'b0;
		apbReq = '0;
		enumIn = '0;
		bootLoad = 1'b0;
		bootState = '0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		chk("reset levels", 31'h00106464, lv());
		@(posedge clk_sys);
		foreach (rows[r]) begin
			c = {};
			for (int i = 0; i < rows[r].n; i++) c.push_back(rows[r].cmd[47-8*i -: 8]);
			t = rows[r].cmd[47:40];
			pkt(c, '{rows[r].ok ? t | lsch_pkg::RSP_FLAG : (t & lsch_pkg::LOW6_MASK) | lsch_pkg::ERR_FLAG, 8'h00});
			chk("cursor and levels", rows[r].st, lv());
		end
		apb(1'b0, lsch_pkg::ADDR_LEVELS, 32'h0);
		chk("levels register", 32'h00221121, rd);
		apb(1'b0, lsch_pkg::ADDR_CURSOR, 32'h0);
		chk("cursor register", 32'h00000015, rd);
		pkt('{8'h09, 8'h09, 8'h07, 8'h3F, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00}, '{8'h49, 8'h00});
		chk("glyph slot 7", 64'h002010080402013F, liveState.glyph[63:56]);
		pkt('{8'h09, 8'h09, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'hC9, 8'h00});
		pkt('{8'h09, 8'h09, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'hC9, 8'h00});
		chk("glyph slot 0", 64'h0, liveState.glyph[7:0]);
		pkt('{8'h0A, 8'h01, 8'h78}, '{8'h4A, 8'h09, 8'h78, 8'h3F, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00});
		pkt('{8'h0A, 8'h01, 8'h90}, '{8'hCA, 8'h00});
		apb(1'b1, lsch_pkg::ADDR_TEXT, 32'h00001041);
		pkt('{8'h0A, 8'h01, 8'hC0}, '{8'h4A, 8'h09, 8'hC0, 8'h41, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20});
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped error", 64'h1, er);
		apb(1'b1, lsch_pkg::ADDR_CTRL, 32'h0);
		@(negedge clk_sys);
		chk("ready when disabled", 64'h0, cmdReady);
		@(posedge clk_sys);
		apb(1'b1, lsch_pkg::ADDR_CTRL, 32'h1);
		for (int k = 0; k < 2; k++) begin
			enumIn <= '{1'b1, k ? 5'd31 : 5'd3, SID};
			@(posedge clk_sys);
		end
		enumIn.valid <= 1'b0;
		host.slow = 1'b1;
		pkt('{8'h12, 8'h01, 8'h03}, '{8'h52, 8'h09, 8'h03, FAM, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01});
		host.slow = 1'b0;
		pkt('{8'h12, 8'h01, 8'h20}, '{8'hD2, 8'h00});
		apb(1'b0, lsch_pkg::ADDR_SENSORS, 32'h0);
		chk("sensor bitmap", 32'h80000008, rd);
		pkt('{8'h13, 8'h04, 8'h08, 8'h00, 8'h00, 8'h80}, '{8'h53, 8'h00});
		chk("report mask", 32'h80000008, reportMask);
		apb(1'b0, lsch_pkg::ADDR_REPORT, 32'h0);
		chk("report register", 32'h80000008, rd);
		ticks(3 * RC);
		chk("tick spacing", RC, tk[1] - tk[0]);
		pkt('{8'h13, 8'h03, 8'h01, 8'h02, 8'h03}, '{8'hD3, 8'h00});
		pkt('{8'h13, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h53, 8'h00});
		ticks(3 * RC);
		chk("ticks when masked", 64'h0, tk.size());
		bootState <= {{64{8'h11}}, 4'h3, 1'b1, 2'h2, 24'h2A3344};
		bootLoad <= 1'b1;
		@(posedge clk_sys);
		bootLoad <= 1'b0;
		@(negedge clk_sys);
		chk("boot load", {2'h2, 1'b1, 4'h3, 24'h2A3344}, lv());
		chk("boot glyph", 8'h11, liveState.glyph[0]);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		chk("mask after reset", 64'h0, reportMask);
		chk("levels after reset", 31'h00106464, lv());
		test_done();
	end
endmodule : test_lcd_sensor_command_handler

// ==== hw/lsch_command_handler.sv ====
// module: packet command handler of the character display
//
// Implementation choices: the APB register port and the register addresses.
module lsch_command_handler #(
	parameter int unsigned REPORT_CYCLES = lsch_pkg::REPORT_CYCLES
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire lsch_pkg::lsch_apb_req_t apbReq,
	output      lsch_pkg::lsch_apb_rsp_t apbRsp,
	input  wire lsch_pkg::lsch_cmd_t     cmdIn,
	output      logic                   cmdReady,
	output      lsch_pkg::lsch_ans_t     ansOut,
	input  wire logic                   ansReady,
	input  wire lsch_pkg::lsch_enum_t    enumIn,
	input  wire logic                   bootLoad,
	input  wire lsch_pkg::lsch_boot_t    bootState,
	output      lsch_pkg::lsch_boot_t    liveState,
	output      logic [31:0]            reportMask,
	output      logic                   reportTick
);

	typedef struct packed {
		lsch_pkg::lsch_fsm_t                         fsm;
		logic [7:0]                                  cmdType;
		logic [7:0]                                  cmdLen;
		logic [7:0]                                  cnt;
		logic [lsch_pkg::CMD_BUF_BYTES-1:0][7:0]     cmdBuf;
		logic [lsch_pkg::ANS_BYTES-1:0][7:0]         ansBuf;
		logic [3:0]                                  ansLeft;
		lsch_pkg::lsch_boot_t                        live;
		logic [31:0][7:0]                            text;
		logic [31:0][7:0][7:0]                       sensorId;
		logic [31:0]                                 sensorPresent;
		logic [31:0]                                 mask;
		logic [31:0]                                 secCnt;
		logic                                        tick;
		logic                                        ctrlEnable;
		logic [15:0]                                 errCount;
		logic                                        apbAck;
		logic [31:0]                                 prdata;
		logic                                        pslverr;
	} lsch_state_t;

	lsch_state_t st;
	lsch_state_t next_st;

	logic       ok;
	logic [7:0] peekAdr;
	logic [3:0] ansLen;
	logic [7:0] ansType;
	logic [8:0][7:0] ansData;
	logic [4:0] sensorIdx;

	assign cmdReady     = st.ctrlEnable &&
	                      (st.fsm == lsch_pkg::ST_TYPE ||
	                       st.fsm == lsch_pkg::ST_LEN ||
	                       st.fsm == lsch_pkg::ST_DATA);
	assign ansOut.valid = (st.fsm == lsch_pkg::ST_ANS);
	assign ansOut.data  = st.ansBuf[0];
	assign ansOut.last  = (st.ansLeft == 4'h1);
	assign apbRsp.pready  = st.apbAck;
	assign apbRsp.prdata  = st.prdata;
	assign apbRsp.pslverr = st.pslverr;
	assign liveState    = st.live;
	assign reportMask   = st.mask;
	assign reportTick   = st.tick;

	always_comb begin
		next_st   = st;
		ok        = 1'b0;
		ansLen    = 4'h0;
		ansData   = '0;
		peekAdr   = st.cmdBuf[0];
		sensorIdx = st.cmdBuf[0][4:0];
		ansType   = 8'h00;

		// once-per-second report tick for the enabled sensors
		next_st.tick = 1'b0;
		if (st.secCnt >= REPORT_CYCLES - 1) begin
			next_st.secCnt = 32'h0;
			next_st.tick   = (st.mask != 32'h0);
		end else begin
			next_st.secCnt = st.secCnt + 32'h1;
		end

		// identifiers delivered by the power-up bus enumeration
		if (enumIn.valid) begin
			next_st.sensorId[enumIn.index]      = enumIn.id;
			next_st.sensorPresent[enumIn.index] = 1'b1;
		end

		unique case (st.fsm)
			lsch_pkg::ST_TYPE: begin
				if (cmdIn.valid && cmdReady) begin
					next_st.cmdType = cmdIn.data;
					next_st.fsm     = lsch_pkg::ST_LEN;
				end
			end
			lsch_pkg::ST_LEN: begin
				if (cmdIn.valid && cmdReady) begin
					next_st.cmdLen = cmdIn.data;
					next_st.cnt    = 8'h00;
					next_st.cmdBuf = '0;
					if (cmdIn.data == 8'h00) begin
						next_st.fsm = lsch_pkg::ST_EXEC;
					end else begin
						next_st.fsm = lsch_pkg::ST_DATA;
					end
				end
			end
			lsch_pkg::ST_DATA: begin
				if (cmdIn.valid && cmdReady) begin
					if (st.cnt < 8'(lsch_pkg::CMD_BUF_BYTES)) begin
						next_st.cmdBuf[st.cnt[3:0]] = cmdIn.data;
					end
					next_st.cnt = st.cnt + 8'h01;
					if (st.cnt + 8'h01 == st.cmdLen) begin
						next_st.fsm = lsch_pkg::ST_EXEC;
					end
				end
			end
			lsch_pkg::ST_EXEC: begin
				case (st.cmdType)
					lsch_pkg::CMD_GLYPH: begin
						ok = (st.cmdLen == lsch_pkg::LEN_GLYPH) &&
						     (st.cmdBuf[0] <= lsch_pkg::GLYPH_SLOT_MAX);
						for (int r = 0; r < 8; r++) begin
							if (st.cmdBuf[r+1] > lsch_pkg::GLYPH_ROW_MAX) begin
								ok = 1'b0;
							end
						end
						if (ok) begin
							for (int r = 0; r < 8; r++) begin
								// row byte r+1 lands in row r, top first, bit 5 leftmost
								next_st.live.glyph[{st.cmdBuf[0][2:0], 3'(r)}] =
									st.cmdBuf[r+1];
							end
						end
					end
					lsch_pkg::CMD_PEEK: begin
						ok = (st.cmdLen == lsch_pkg::LEN_ONE);
						ansData[0] = peekAdr;
						if (peekAdr[7:6] == lsch_pkg::ADR_GLYPH_TAG) begin
							for (int i = 0; i < 8; i++) begin
								ansData[i+1] =
									st.live.glyph[6'(peekAdr[5:0] + 6'(i))];
							end
						end else if (peekAdr[7:4] == lsch_pkg::ADR_LINE1_TAG) begin
							for (int i = 0; i < 8; i++) begin
								ansData[i+1] =
									st.text[{1'b0, 4'(peekAdr[3:0] + 4'(i))}];
							end
						end else if (peekAdr[7:4] == lsch_pkg::ADR_LINE2_TAG) begin
							for (int i = 0; i < 8; i++) begin
								ansData[i+1] =
									st.text[{1'b1, 4'(peekAdr[3:0] + 4'(i))}];
							end
						end else begin
							ok = 1'b0;
						end
						ansLen = lsch_pkg::LEN_ANS_ID;
					end
					lsch_pkg::CMD_CURSOR_POS: begin
						ok = (st.cmdLen == lsch_pkg::LEN_TWO) &&
						     (st.cmdBuf[0] <= lsch_pkg::COL_MAX) &&
						     (st.cmdBuf[1] <= lsch_pkg::ROW_MAX);
						if (ok) begin
							next_st.live.curCol = st.cmdBuf[0][3:0];
							next_st.live.curRow = st.cmdBuf[1][0];
						end
					end
					lsch_pkg::CMD_CURSOR_STY: begin
						ok = (st.cmdLen == lsch_pkg::LEN_ONE) &&
						     (st.cmdBuf[0] <= lsch_pkg::STYLE_MAX);
						if (ok) begin
							// 0 none, 1 blinking block, 2 underscore, 3 blinking underscore
							next_st.live.curStyle = st.cmdBuf[0][1:0];
						end
					end
					lsch_pkg::CMD_CONTRAST: begin
						if (st.cmdLen == lsch_pkg::LEN_ONE) begin
							ok = (st.cmdBuf[0] <= lsch_pkg::CONTRAST_MAX);
							if (ok) begin
								next_st.live.contrast = st.cmdBuf[0];
							end
						end else if (st.cmdLen == lsch_pkg::LEN_TWO) begin
							ok = 1'b1;
							next_st.live.contrast = st.cmdBuf[1];
						end
					end
					lsch_pkg::CMD_BACKLIGHT: begin
						if (st.cmdLen == lsch_pkg::LEN_ONE) begin
							ok = 1'b1;
							next_st.live.lcdLight = st.cmdBuf[0];
							next_st.live.keyLight = st.cmdBuf[0];
						end else if (st.cmdLen == lsch_pkg::LEN_TWO) begin
							ok = 1'b1;
							next_st.live.lcdLight = st.cmdBuf[0];
							next_st.live.keyLight = st.cmdBuf[1];
						end
					end
					lsch_pkg::CMD_SENSOR_ID: begin
						ok = (st.cmdLen == lsch_pkg::LEN_ONE) &&
						     (st.cmdBuf[0] <= lsch_pkg::SENSOR_MAX);
						ansData[0] = st.cmdBuf[0];
						for (int k = 0; k < 8; k++) begin
							// byte 0 of the identifier holds the family code
							ansData[k+1] = st.sensorId[sensorIdx][k];
						end
						ansLen = lsch_pkg::LEN_ANS_ID;
					end
					lsch_pkg::CMD_REPORT: begin
						ok = (st.cmdLen == lsch_pkg::LEN_REPORT);
						if (ok) begin
							next_st.mask = {st.cmdBuf[3], st.cmdBuf[2],
							                st.cmdBuf[1], st.cmdBuf[0]};
						end
					end
					default: begin
						ok = 1'b0;
					end
				endcase
				if (ok) begin
					ansType = st.cmdType | lsch_pkg::RSP_FLAG;
				end else begin
					ansType = (st.cmdType & lsch_pkg::LOW6_MASK) |
					          lsch_pkg::ERR_FLAG;
					ansLen  = 4'h0;
					next_st.errCount = st.errCount + 16'h1;
				end
				next_st.ansBuf  = {ansData, {4'h0, ansLen}, ansType};
				next_st.ansLeft = ansLen + lsch_pkg::ANS_HDR_BYTES;
				next_st.fsm     = lsch_pkg::ST_ANS;
			end
			lsch_pkg::ST_ANS: begin
				if (ansReady) begin
					next_st.ansBuf  = {8'h00, st.ansBuf[lsch_pkg::ANS_BYTES-1:1]};
					next_st.ansLeft = st.ansLeft - 4'h1;
					if (st.ansLeft == 4'h1) begin
						next_st.fsm = lsch_pkg::ST_TYPE;
					end
				end
			end
			default: begin
				// illegal one-hot code: back to idle
				next_st.fsm = lsch_pkg::ST_TYPE;
			end
		endcase

		// restore of the saved boot state
		if (bootLoad) begin
			next_st.live = bootState;
		end

		// apb slave: read data latched on first access cycle, one wait state
		next_st.apbAck = 1'b0;
		if (apbReq.psel && apbReq.penable && !st.apbAck) begin
			next_st.apbAck  = 1'b1;
			next_st.pslverr = 1'b0;
			next_st.prdata  = 32'h0;
			case (apbReq.paddr)
				lsch_pkg::ADDR_CTRL:
					next_st.prdata = {31'h0, st.ctrlEnable};
				lsch_pkg::ADDR_STATUS:
					next_st.prdata = {st.errCount, 7'h00,
					                  (st.fsm != lsch_pkg::ST_TYPE), st.cmdType};
				lsch_pkg::ADDR_CURSOR:
					next_st.prdata = {22'h0, st.live.curStyle, 3'h0,
					                  st.live.curRow, st.live.curCol};
				lsch_pkg::ADDR_LEVELS:
					next_st.prdata = {8'h00, st.live.keyLight,
					                  st.live.lcdLight, st.live.contrast};
				lsch_pkg::ADDR_REPORT:
					next_st.prdata = st.mask;
				lsch_pkg::ADDR_TEXT:
					next_st.prdata = 32'h0;
				lsch_pkg::ADDR_SENSORS:
					next_st.prdata = st.sensorPresent;
				default:
					next_st.pslverr = 1'b1;
			endcase
		end
		if (apbReq.psel && apbReq.penable && st.apbAck && apbReq.pwrite) begin
			if (apbReq.paddr == lsch_pkg::ADDR_CTRL) begin
				next_st.ctrlEnable = apbReq.pwdata[0];
			end else if (apbReq.paddr == lsch_pkg::ADDR_TEXT) begin
				next_st.text[apbReq.pwdata[12:8]] = apbReq.pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st                <= '0;
			st.fsm            <= lsch_pkg::ST_TYPE;
			st.text           <= {32{lsch_pkg::TEXT_BLANK}};
			st.live.contrast  <= lsch_pkg::RST_CONTRAST;
			st.live.lcdLight  <= lsch_pkg::RST_LIGHT;
			st.live.keyLight  <= lsch_pkg::RST_LIGHT;
			st.ctrlEnable     <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule : lsch_command_handler

// ==== hw/lsch_pkg.sv ====
// package: constants, types and carriers of the display command handler
package lsch_pkg;

	// command and answer type codes
	localparam logic [7:0] CMD_GLYPH      = 8'h09;
	localparam logic [7:0] CMD_PEEK       = 8'h0A;
	localparam logic [7:0] CMD_CURSOR_POS = 8'h0B;
	localparam logic [7:0] CMD_CURSOR_STY = 8'h0C;
	localparam logic [7:0] CMD_CONTRAST   = 8'h0D;
	localparam logic [7:0] CMD_BACKLIGHT  = 8'h0E;
	localparam logic [7:0] CMD_SENSOR_ID  = 8'h12;
	localparam logic [7:0] CMD_REPORT     = 8'h13;
	localparam logic [7:0] RSP_FLAG       = 8'h40;
	localparam logic [7:0] ERR_FLAG       = 8'hC0;
	localparam logic [7:0] LOW6_MASK      = 8'h3F;

	// lengths and limits
	localparam logic [7:0] LEN_GLYPH      = 8'h09;
	localparam logic [7:0] LEN_ONE        = 8'h01;
	localparam logic [7:0] LEN_TWO        = 8'h02;
	localparam logic [7:0] LEN_REPORT     = 8'h04;
	localparam logic [3:0] LEN_ANS_ID     = 4'h9;
	localparam logic [7:0] GLYPH_SLOT_MAX = 8'h07;
	localparam logic [7:0] GLYPH_ROW_MAX  = 8'h3F;
	localparam logic [7:0] COL_MAX        = 8'h0F;
	localparam logic [7:0] ROW_MAX        = 8'h01;
	localparam logic [7:0] STYLE_MAX      = 8'h03;
	localparam logic [7:0] CONTRAST_MAX   = 8'hC8;
	localparam logic [7:0] SENSOR_MAX     = 8'h1F;
	localparam int         CMD_BUF_BYTES  = 16;
	localparam int         ANS_BYTES      = 11;
	localparam logic [3:0] ANS_HDR_BYTES  = 4'h2;

	// controller memory address codes
	localparam logic [1:0] ADR_GLYPH_TAG  = 2'h1;
	localparam logic [3:0] ADR_LINE1_TAG  = 4'h8;
	localparam logic [3:0] ADR_LINE2_TAG  = 4'hC;

	// reset values
	localparam logic [7:0] TEXT_BLANK     = 8'h20;
	localparam logic [7:0] RST_CONTRAST   = 8'h10;
	localparam logic [7:0] RST_LIGHT      = 8'h64;

	// register map, byte addresses
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_CURSOR    = 8'h08;
	localparam logic [7:0] ADDR_LEVELS    = 8'h0C;
	localparam logic [7:0] ADDR_REPORT    = 8'h10;
	localparam logic [7:0] ADDR_TEXT      = 8'h14;
	localparam logic [7:0] ADDR_SENSORS   = 8'h18;

	// report period
	localparam int REPORT_PERIOD_MS = 1000;
	localparam int CLK_MHZ          = 250;
	localparam int REPORT_CYCLES    = REPORT_PERIOD_MS * 1000 * CLK_MHZ;

	typedef enum logic [4:0] {
		ST_TYPE = 5'h01,
		ST_LEN  = 5'h02,
		ST_DATA = 5'h04,
		ST_EXEC = 5'h08,
		ST_ANS  = 5'h10
	} lsch_fsm_t;

	// state kept as boot state: glyph slot s row r at index s*8+r
	typedef struct packed {
		logic [63:0][7:0] glyph;
		logic [3:0]       curCol;
		logic             curRow;
		logic [1:0]       curStyle;
		logic [7:0]       contrast;
		logic [7:0]       lcdLight;
		logic [7:0]       keyLight;
	} lsch_boot_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} lsch_cmd_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} lsch_ans_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  index;
		logic [63:0] id;
	} lsch_enum_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} lsch_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} lsch_apb_rsp_t;

endpackage : lsch_pkg
